// [pkg/shutdown_pkg.sv]
// constants, field layouts and types for the regulator power-down sequencer
// assumes a 25 MHz APB clock and seven regulator enable outputs
// Function
// [R1] each order slot sits in bits 2..0 of its own register; bits 7..3 unused
// [R2] seven slots: three bucks, three linear regulators, DDR reference
// [R3] after reset each slot takes its fused power-up order value
// [R4] when triggered, regulators switch off one slot group at a time, highest slot first
// [R5] host may rewrite any slot while the system is in a system-on state
// [R6] power-up order comes only from fuses; slot writes never change it
// [R7] all slots zero: sequencer skipped, every regulator switched off at once
// [R8] equal nonzero slots switch off together; fixed delay between steps
package shutdown_pkg;

    localparam int SLOT_COUNT = 7;
    localparam int SLOT_WIDTH = 3;
    localparam int ADDR_WIDTH = 12;

    // regulator positions in every per-regulator vector
    localparam int BUCK_ONE      = 0;
    localparam int BUCK_TWO      = 1;
    localparam int BUCK_THREE    = 2;
    localparam int LINEAR_ONE    = 3;
    localparam int LINEAR_TWO    = 4;
    localparam int LINEAR_THREE  = 5;
    localparam int DDR_REFERENCE = 6;

    // register indices; byte address is four times the index
    localparam logic [7:0] BUCK_ONE_SHUTDOWN_ORDER      = 8'h5F;
    localparam logic [7:0] BUCK_TWO_SHUTDOWN_ORDER      = 8'h60;
    localparam logic [7:0] BUCK_THREE_SHUTDOWN_ORDER    = 8'h61;
    localparam logic [7:0] LDO_ONE_SHUTDOWN_ORDER       = 8'h62;
    localparam logic [7:0] LDO_TWO_SHUTDOWN_ORDER       = 8'h63;
    localparam logic [7:0] LINEAR_THREE_SHUTDOWN_ORDER  = 8'h64;
    localparam logic [7:0] DDR_REFERENCE_SHUTDOWN_ORDER = 8'h65;
    localparam logic [7:0] SEQUENCER_CONTROL            = 8'h70;
    localparam logic [7:0] SEQUENCER_STATUS             = 8'h71;

    localparam logic [6:0][7:0] SLOT_INDEX = {
        DDR_REFERENCE_SHUTDOWN_ORDER, LINEAR_THREE_SHUTDOWN_ORDER,
        LDO_TWO_SHUTDOWN_ORDER, LDO_ONE_SHUTDOWN_ORDER,
        BUCK_THREE_SHUTDOWN_ORDER, BUCK_TWO_SHUTDOWN_ORDER,
        BUCK_ONE_SHUTDOWN_ORDER};

    localparam logic [2:0] SLOT_RESET = 3'h0;

    // control fields (write one to act, read as zero)
    localparam int CONTROL_START_BIT   = 0;
    localparam int CONTROL_RESTORE_BIT = 1;

    // status fields
    localparam int STATUS_BUSY_BIT   = 0;
    localparam int STATUS_DONE_BIT   = 1;
    localparam int STATUS_BYPASS_BIT = 2;
    localparam int STATUS_LEVEL_LSB  = 4;
    localparam int STATUS_ENABLE_LSB = 8;

    localparam logic [6:0] ENABLE_RESET = 7'h7F;

    // delay between successive shutdown steps
    localparam int STEP_TIME_NS    = 2000;
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int STEP_CYCLES     = (STEP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WAIT = 2'b01,
        SEQ_DONE = 2'b11
    } seq_state_t;

endpackage

// [design/slot_register.sv]
// one power-down order slot of three bits
// assumes the fused value is stable from reset release onward
`timescale 1ns/1ps
module slot_register
    import shutdown_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // fused start-up order of this regulator
    input  wire logic [SLOT_WIDTH-1:0] fused_slot,
    // host write
    input  wire logic                  write_strobe,
    input  wire logic [SLOT_WIDTH-1:0] write_data,
    // current slot value
    output logic      [SLOT_WIDTH-1:0] slot
);
    typedef struct packed {
        logic                  loaded;
        logic [SLOT_WIDTH-1:0] value;
    } slot_state_t;

    slot_state_t cur;
    slot_state_t next_cur;

    always_comb begin
        next_cur = cur;
        if (!cur.loaded) begin
            // catch the fused order on the first edge after reset release
            next_cur.loaded = 1'b1;
            next_cur.value  = fused_slot; // see [R3]
        end else if (write_strobe) begin
            next_cur.value = write_data; // see [R5]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '{loaded: 1'b0, value: SLOT_RESET};
        end else begin
            cur <= next_cur;
        end
    end

    assign slot = cur.value;
endmodule

// [design/step_timer.sv]
// down counter that spaces the shutdown steps
// assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
module step_timer #(
    parameter int CYCLES = 50
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic start,
    // high in the last cycle of the delay
    output logic      expired
);
    localparam int WIDTH = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } timer_state_t;

    timer_state_t cur;
    timer_state_t next_cur;

    always_comb begin
        next_cur = cur;
        if (start) begin
            next_cur.count = WIDTH'(CYCLES);
        end else if (cur.count != '0) begin
            next_cur.count = cur.count - WIDTH'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '{count: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign expired = (cur.count == WIDTH'(1));
endmodule

// [design/regulator_power_down_sequencer.sv]
// power-down sequencer: APB register slave, seven order slots and the
// step engine that drops the regulator enables
// assumes all inputs synchronous to pclk and a zero-wait APB master
`timescale 1ns/1ps
module regulator_power_down_sequencer
    import shutdown_pkg::*;
#(
    parameter int STEP_DELAY_CYCLES = STEP_CYCLES
) (
    // clock and reset
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    // apb slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [shutdown_pkg::ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // fused start-up order of each regulator
    input  wire logic [shutdown_pkg::SLOT_WIDTH-1:0] fused_buck_one_startup_slot,
    input  wire logic [shutdown_pkg::SLOT_WIDTH-1:0] fused_buck_two_startup_slot,
    input  wire logic [shutdown_pkg::SLOT_WIDTH-1:0] fused_buck_three_startup_slot,
    input  wire logic [shutdown_pkg::SLOT_WIDTH-1:0] fused_linear_one_startup_slot,
    input  wire logic [shutdown_pkg::SLOT_WIDTH-1:0] fused_linear_two_startup_slot,
    input  wire logic [shutdown_pkg::SLOT_WIDTH-1:0] fused_linear_three_startup_slot,
    input  wire logic [shutdown_pkg::SLOT_WIDTH-1:0] fused_ddr_reference_startup_slot,
    // system state and trigger
    input  wire logic                             system_on,
    input  wire logic                             shutdown_trigger,
    // regulator enables and progress
    output logic      [shutdown_pkg::SLOT_COUNT-1:0] regulator_enable,
    output logic                                  sequence_busy,
    output logic                                  sequence_done
);
    typedef struct packed {
        seq_state_t            fsm;
        logic [SLOT_COUNT-1:0] enable;
        logic [SLOT_WIDTH-1:0] level;
        logic                  bypassed;
        logic [31:0]           rdata;
        logic                  slverr;
    } core_state_t;

    core_state_t cur;
    core_state_t next_cur;

    logic [SLOT_COUNT-1:0][SLOT_WIDTH-1:0] fused;
    logic [SLOT_COUNT-1:0][SLOT_WIDTH-1:0] slot;
    logic [SLOT_COUNT-1:0]                 slot_write;

    logic       setup_phase;
    logic       write_access;
    logic       aligned;
    logic [7:0] index;
    logic       control_write;
    logic       start_request;
    logic       restore_request;
    logic       timer_start;
    logic       timer_expired;

    assign fused[BUCK_ONE]      = fused_buck_one_startup_slot;
    assign fused[BUCK_TWO]      = fused_buck_two_startup_slot;
    assign fused[BUCK_THREE]    = fused_buck_three_startup_slot;
    assign fused[LINEAR_ONE]    = fused_linear_one_startup_slot;
    assign fused[LINEAR_TWO]    = fused_linear_two_startup_slot;
    assign fused[LINEAR_THREE]  = fused_linear_three_startup_slot;
    assign fused[DDR_REFERENCE] = fused_ddr_reference_startup_slot;

    // address decode: word aligned, upper address bits must be zero
    assign index        = paddr[9:2];
    assign aligned      = (paddr[1:0] == 2'h0) && (paddr[ADDR_WIDTH-1:10] == '0);
    assign setup_phase  = psel && !penable;
    assign write_access = psel && penable && pwrite;

    // host writes change the slots only while a system-on state holds
    // the fused inputs feed the slots only, never the reverse
    genvar g;
    generate
        for (g = 0; g < SLOT_COUNT; g++) begin : gen_slot // see [R2]
            assign slot_write[g] = write_access && aligned && system_on
                                   && (index == SLOT_INDEX[g]); // see [R5]
            slot_register u_slot (
                .pclk         (pclk),
                .presetn      (presetn),
                .fused_slot   (fused[g]), // see [R6]
                .write_strobe (slot_write[g]),
                .write_data   (pwdata[SLOT_WIDTH-1:0]), // see [R1]
                .slot         (slot[g])
            );
        end
    endgenerate

    assign control_write   = write_access && aligned && (index == SEQUENCER_CONTROL);
    assign start_request   = shutdown_trigger
                             || (control_write && pwdata[CONTROL_START_BIT]);
    assign restore_request = control_write && pwdata[CONTROL_RESTORE_BIT];

    step_timer #(
        .CYCLES (STEP_DELAY_CYCLES)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (timer_start),
        .expired (timer_expired)
    );

    // highest slot among regulators still enabled
    function automatic logic [SLOT_WIDTH-1:0] top_level(
        input logic [SLOT_COUNT-1:0]                 on,
        input logic [SLOT_COUNT-1:0][SLOT_WIDTH-1:0] order
    );
        logic [SLOT_WIDTH-1:0] best;
        best = '0;
        for (int i = 0; i < SLOT_COUNT; i++) begin
            if (on[i] && (order[i] > best)) begin
                best = order[i];
            end
        end
        return best;
    endfunction

    // regulators still on whose slot matches the level being dropped
    function automatic logic [SLOT_COUNT-1:0] at_level(
        input logic [SLOT_COUNT-1:0]                 on,
        input logic [SLOT_COUNT-1:0][SLOT_WIDTH-1:0] order,
        input logic [SLOT_WIDTH-1:0]                 lvl
    );
        logic [SLOT_COUNT-1:0] hit;
        hit = '0;
        for (int i = 0; i < SLOT_COUNT; i++) begin
            hit[i] = on[i] && (order[i] == lvl);
        end
        return hit;
    endfunction

    // read data for the addressed register, captured in the setup phase
    function automatic logic [31:0] read_word(
        input logic [7:0]                            idx,
        input logic [SLOT_COUNT-1:0][SLOT_WIDTH-1:0] order,
        input core_state_t                           st
    );
        logic [31:0] word;
        word = 32'h0;
        for (int i = 0; i < SLOT_COUNT; i++) begin
            if (idx == SLOT_INDEX[i]) begin
                word[SLOT_WIDTH-1:0] = order[i]; // see [R1]
            end
        end
        if (idx == SEQUENCER_STATUS) begin
            word[STATUS_BUSY_BIT]   = (st.fsm == SEQ_WAIT);
            word[STATUS_DONE_BIT]   = (st.fsm == SEQ_DONE);
            word[STATUS_BYPASS_BIT] = st.bypassed;
            word[STATUS_LEVEL_LSB +: SLOT_WIDTH]  = st.level;
            word[STATUS_ENABLE_LSB +: SLOT_COUNT] = st.enable;
        end
        return word;
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        logic hit;
        hit = (idx == SEQUENCER_CONTROL) || (idx == SEQUENCER_STATUS);
        for (int i = 0; i < SLOT_COUNT; i++) begin
            hit = hit || (idx == SLOT_INDEX[i]);
        end
        return hit;
    endfunction

    always_comb begin
        logic [SLOT_WIDTH-1:0] lvl;
        logic [SLOT_COUNT-1:0] drop;
        logic [SLOT_COUNT-1:0] left;
        lvl         = top_level(cur.enable, slot);
        drop        = at_level(cur.enable, slot, lvl);
        left        = cur.enable & ~drop;
        next_cur    = cur;
        timer_start = 1'b0;

        if (setup_phase) begin
            // refused (unaligned) reads return zero even when the index maps
            next_cur.rdata  = (pwrite || !aligned) ? 32'h0 : read_word(index, slot, cur);
            next_cur.slverr = !(aligned && mapped(index));
        end

        unique case (cur.fsm)
            SEQ_IDLE: begin
                if (restore_request) begin
                    next_cur.enable = ENABLE_RESET;
                end else if (start_request) begin
                    next_cur.bypassed = 1'b0;
                    if (slot == '0) begin
                        // every slot zero: all regulators off in one step
                        next_cur.enable   = '0; // see [R7]
                        next_cur.bypassed = 1'b1;
                        next_cur.level    = '0;
                        next_cur.fsm      = SEQ_DONE;
                    end else begin
                        // first step drops the highest slot group
                        next_cur.enable = left; // see [R4] [R8]
                        next_cur.level  = lvl;
                        if (left == '0) begin
                            next_cur.fsm = SEQ_DONE;
                        end else begin
                            timer_start  = 1'b1; // see [R8]
                            next_cur.fsm = SEQ_WAIT;
                        end
                    end
                end
            end
            SEQ_WAIT: begin
                if (timer_expired) begin
                    // next lower group after the fixed step delay
                    next_cur.enable = left; // see [R4] [R8]
                    next_cur.level  = lvl;
                    if (left == '0) begin
                        next_cur.fsm = SEQ_DONE;
                    end else begin
                        timer_start = 1'b1;
                    end
                end
            end
            SEQ_DONE: begin
                if (restore_request) begin
                    next_cur.enable   = ENABLE_RESET;
                    next_cur.bypassed = 1'b0;
                    next_cur.level    = '0;
                    next_cur.fsm      = SEQ_IDLE;
                end
            end
            default: begin
                next_cur.fsm = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '{fsm:      SEQ_IDLE,
                     enable:   ENABLE_RESET,
                     level:    SLOT_RESET,
                     bypassed: 1'b0,
                     rdata:    32'h0,
                     slverr:   1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata           = cur.rdata;
    assign pslverr          = cur.slverr && psel && penable;
    assign pready           = 1'b1;
    assign regulator_enable = cur.enable;
    assign sequence_busy    = (cur.fsm == SEQ_WAIT);
    assign sequence_done    = (cur.fsm == SEQ_DONE);
endmodule

// [test/shutdown_chk.sv]
// checker on the power-down sequencer top ports
// assumes a bind that hands on the sequencer's step delay
`timescale 1ns/1ps
module shutdown_chk
    import shutdown_pkg::*;
#(
    parameter int STEP_DELAY_CYCLES = 3
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           prdata,
    input  wire logic                  pready,
    input  wire logic                  pslverr,
    // sequencer
    input  wire logic                  shutdown_trigger,
    input  wire logic [SLOT_COUNT-1:0] regulator_enable,
    input  wire logic                  sequence_busy,
    input  wire logic                  sequence_done
);
    logic [SLOT_COUNT-1:0] prev_en;
    int                    gap;
    logic                  drop;
    logic                  idle;
    assign drop = |(prev_en & ~regulator_enable);
    assign idle = !sequence_busy && !sequence_done && regulator_enable == ENABLE_RESET;
    // gap counts edges since the last group of enables fell
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_en <= ENABLE_RESET;
            gap     <= 0;
        end else begin
            prev_en <= regulator_enable;
            gap     <= drop ? 1 : (gap < 1000 ? gap + 1 : gap);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    err_in_access_a: assert property (pslverr |-> psel && penable && pready && prdata == 32'h0)
        else $error("slave error outside access phase or with data");
    slot_upper_zero_a: assert property (psel && penable && !pwrite && paddr >= 12'h17C
        && paddr <= 12'h194 |-> prdata[31:3] == 29'h0) else $error("slot upper bits set");
    trigger_acts_a: assert property (idle && shutdown_trigger |=>
        regulator_enable != ENABLE_RESET) else $error("trigger ignored in idle");
    all_at_once_a: assert property (idle && shutdown_trigger |=>
        sequence_done == (regulator_enable == 7'h00)) else $error("done and all off differ");
    step_spacing_a: assert property (drop && $past(sequence_busy) |->
        gap == STEP_DELAY_CYCLES) else $error("step spacing wrong");
    no_early_step_a: assert property (sequence_busy && !drop |->
        gap < STEP_DELAY_CYCLES) else $error("busy past the step time");
    done_all_off_a: assert property (sequence_done |->
        regulator_enable == 7'h00 && !sequence_busy) else $error("done with rails on");
    only_fall_busy_a: assert property (sequence_busy |=>
        (regulator_enable & ~$past(regulator_enable)) == 7'h00) else $error("enable rose");
    done_hold_a: assert property (sequence_done && !(psel && penable && pwrite) |=>
        sequence_done) else $error("done dropped without a write");
    cover property (idle && shutdown_trigger);
    cover property (drop && $past(sequence_busy));
    cover property (pslverr);
endmodule

// [test/regulator_rails.sv]
// model of the regulators behind the enable outputs
// assumes each rail follows its enable one clock later
`timescale 1ns/1ps
module regulator_rails (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // enables from the sequencer
    input  wire logic [6:0] regulator_enable,
    // rails that are up
    output logic      [6:0] rail_up
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rail_up <= 7'h7F;
        else
            rail_up <= regulator_enable;
    end
endmodule

// [test/test_regulator_power_down_sequencer.sv]
// testbench for the power-down sequencer with a model of the slots
// assumes the package constants and a zero-wait apb slave
`timescale 1ns/1ps
module test_regulator_power_down_sequencer;
    import shutdown_pkg::*;
    localparam int D = 3;
    logic             pclk, presetn, psel, penable, pwrite, system_on, shutdown_trigger;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rd, w;
    logic             pready, pslverr, er, sequence_busy, sequence_done;
    logic [6:0]       regulator_enable, rail_up;
    logic [6:0][2:0]  fused;
    int               slot_m[7];
    int               n_mismatch, n_compared;

    regulator_power_down_sequencer #(.STEP_DELAY_CYCLES(D)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .fused_buck_one_startup_slot(fused[0]), .fused_buck_two_startup_slot(fused[1]),
        .fused_buck_three_startup_slot(fused[2]), .fused_linear_one_startup_slot(fused[3]),
        .fused_linear_two_startup_slot(fused[4]), .fused_linear_three_startup_slot(fused[5]),
        .fused_ddr_reference_startup_slot(fused[6]), .system_on(system_on),
        .shutdown_trigger(shutdown_trigger), .regulator_enable(regulator_enable),
        .sequence_busy(sequence_busy), .sequence_done(sequence_done));
    regulator_rails rails (.pclk(pclk), .presetn(presetn),
        .regulator_enable(regulator_enable), .rail_up(rail_up));

    always #20 pclk = ~pclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (k == 20) begin
            n_mismatch++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    function automatic logic [11:0] slot_addr(input int i);
        return {2'b00, SLOT_INDEX[i], 2'b00};
    endfunction

    task automatic do_reset(input int n);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (n) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 7; i++)
            slot_m[i] = fused[i];
    endtask

    task automatic read_slots;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, slot_addr(i), 32'h0);
            chk("slot", slot_m[i], rd);
        end
    endtask

    // expected enables fall group by group, highest slot value first
    task automatic run_seq(input logic by_pin);
        logic [6:0] en;
        logic [6:0] grp;
        bit         first;
        bit         byp;
        int         last;
        en = 7'h7F;
        first = 1;
        byp = 0;
        last = 0;
        if (by_pin) begin
            @(posedge pclk);
            shutdown_trigger <= 1'b1;
            @(posedge pclk);
            shutdown_trigger <= 1'b0;
        end else
            apb(1'b1, 12'h1C0, 32'h1);
        #1;
        for (int l = 7; l >= 0; l--) begin
            grp = 7'h00;
            for (int i = 0; i < 7; i++)
                grp[i] = (slot_m[i] == l);
            if (grp != 7'h00) begin
                if (!first) begin
                    repeat (D) @(posedge pclk);
                    #1;
                end
                byp = first && (l == 0);
                first = 0;
                en = en & ~grp;
                last = l;
                chk("enable", en, regulator_enable);
                chk("busy", en != 7'h00, sequence_busy);
            end
        end
        chk("done", 1, sequence_done);
        chk("busy", 0, sequence_busy);
        @(posedge pclk);
        #1;
        chk("rails", 0, rail_up);
        // status: done, bypass flag, last level dropped, all enables low
        apb(1'b0, 12'h1C4, 32'h0);
        chk("status", (last << 4) | (int'(byp) << 2) | 2, rd);
    endtask

    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        system_on = 1;
        shutdown_trigger = 0;
        n_mismatch = 0;
        n_compared = 0;
        void'($urandom(82));
        fused = 21'($urandom);
        do_reset(20);
        read_slots();
        apb(1'b0, 12'h1FC, 32'h0);
        chk("unmapped error", 1, er);
        chk("unmapped data", 0, rd);
        apb(1'b0, slot_addr(3) + 12'h1, 32'h0);
        chk("unaligned error", 1, er);
        chk("unaligned data", 0, rd);
        run_seq(1'b1);
        apb(1'b1, 12'h1C0, 32'h2);
        chk("restore", 7'h7F, regulator_enable);
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 7; i++) begin
                slot_m[i] = (r == 3) ? 0 : $urandom_range(7, 0);
                w = $urandom;
                w[2:0] = slot_m[i][2:0];
                apb(1'b1, slot_addr(i), w);
            end
            read_slots();
            run_seq(r[0]);
            apb(1'b1, 12'h1C0, 32'h2);
            chk("restore", 7'h7F, regulator_enable);
        end
        @(posedge pclk);
        system_on <= 1'b0;
        apb(1'b1, slot_addr(3), 32'h5);
        read_slots();
        @(posedge pclk);
        system_on <= 1'b1;
        do_reset(3);
        chk("reset enables", 7'h7F, regulator_enable);
        read_slots();
        finish_test();
    end
endmodule

bind regulator_power_down_sequencer shutdown_chk #(.STEP_DELAY_CYCLES(STEP_DELAY_CYCLES)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_trigger(shutdown_trigger), .regulator_enable(regulator_enable),
    .sequence_busy(sequence_busy), .sequence_done(sequence_done));
